// ===== core/pcsad_top.sv
// Configuration space address decode for a six-port switch
// Summary of operation
// RULE1: Upstream port 0 configuration space sits at system base 0x0000.
// RULE2: Downstream ports 1 to 5 sit at port number times 0x1000.
// RULE3: System address is port base plus configuration offset.
// RULE4: EEPROM and SMBus accesses use system address, not per-port offset.
// RULE5: Every register lives in some port space, reachable by the root.
// RULE6: Global control and test registers decode only in the upstream port.
// RULE7: Downstream ports hold an MSI structure; the upstream port does not.
// RULE8: PCIe reads of unimplemented offsets return zero.
// RULE9: SMBus reads of unimplemented offsets return undefined data.
// RULE10: Writes to unimplemented offsets complete but change nothing.
// RULE11: Port numbers above 5 count as unimplemented offsets.
`timescale 1ns/1ps
module pcsad_top
	import pcsad_pkg::*;
(
	input  wire logic                         CLK_I,
	input  wire logic                         RST_N_I,
	input  wire logic                         REQ_I,
	input  wire pcsad_pkg::pcsad_src_e        SRC_I,
	input  wire logic                         WR_I,
	input  wire logic [pcsad_pkg::PORT_AW-1:0] CFG_PORT_I,
	input  wire logic [pcsad_pkg::SYS_AW-1:0] SYS_ADDR_I,
	input  wire logic [3:0]                   BE_I,
	input  wire logic [pcsad_pkg::DW-1:0]     WDATA_I,
	output logic                              ACK_O,
	output logic                              HIT_O,
	output logic      [pcsad_pkg::DW-1:0]     RDATA_O
);
	import pcsad_pkg::*;

	localparam int MEM_AW = PORT_AW + OFF_AW - 2;

	logic [PORT_AW-1:0] port;
	logic [OFF_AW-1:0]  offs;
	logic [9:0]         dw;
	logic               impl;
	logic               mem_we;
	logic [DW-1:0]      mem_rdata;
	logic [DW-1:0]      miss_data;

	logic               port_ok;
	logic               in_hdr;
	logic               in_msi;
	logic               in_ext;
	logic               in_glob;
	logic               in_test;

	logic               pend;
	logic               next_pend;
	logic               pend_hit;
	logic               next_pend_hit;
	pcsad_src_e         pend_src;
	pcsad_src_e         next_pend_src;
	logic               pend_wr;
	logic               next_pend_wr;
	logic               ack;
	logic               next_ack;
	logic               hit;
	logic               next_hit;
	logic [DW-1:0]      rdata;
	logic [DW-1:0]      next_rdata;

	// Address split
	// PCIe requests name the port apart; the address lines carry only the offset
	always_comb begin
		logic [15:0] sys;
		sys = {1'b0, SYS_ADDR_I};
		if (SRC_I == PCSAD_SRC_PCIE) begin
			port = CFG_PORT_I; // RULE5
			offs = SYS_ADDR_I[OFF_AW-1:0];
		end else begin
			port = sys[14:12]; // RULE4
			offs = sys[11:0]; // RULE3
		end
	end

	assign dw = offs[11:2];

	// Range flags for each register group
	always_comb begin
		port_ok = (port <= LAST_PORT); // RULE11
		in_hdr  = (dw >= STD_HDR_LO) && (dw <= STD_HDR_HI);
		in_msi  = (dw >= MSI_LO) && (dw <= MSI_HI);
		in_ext  = (dw >= EXT_LO) && (dw <= EXT_HI);
		in_glob = (dw >= GLOBAL_LO) && (dw <= GLOBAL_HI);
		in_test = (dw >= TEST_LO) && (dw <= TEST_HI);
	end

	// Which groups exist in the addressed port
	// MSI window lies inside the header range, so it is tested first
	always_comb begin
		impl = 1'b0;
		if (!port_ok) begin
			impl = 1'b0; // RULE11
		end else if (in_msi) begin
			impl = (port != UP_PORT); // RULE7
		end else if (in_hdr) begin
			impl = 1'b1; // RULE1 RULE2
		end else if (in_ext) begin
			impl = 1'b1; // RULE5
		end else if (in_glob) begin
			impl = (port == UP_PORT); // RULE6
		end else if (in_test) begin
			impl = (port == UP_PORT); // RULE6
		end else begin
			impl = 1'b0;
		end
	end

	// Write gate: only implemented words of existing ports are stored
	always_comb begin
		mem_we = 1'b0;
		if (REQ_I && WR_I) begin
			if (impl) begin
				mem_we = 1'b1;
			end else begin
				mem_we = 1'b0; // RULE10
			end
		end
	end

	// Fill value for reads of unimplemented offsets
	always_comb begin
		case (pend_src)
			PCSAD_SRC_PCIE: begin
				miss_data = ZERO_DATA; // RULE8
			end
			default: begin
				miss_data = UNDEF_DATA; // RULE9
			end
		endcase
	end

	pcsad_regmem #(
		.AW (MEM_AW),
		.DW (DW)
	) u_mem (
		.clk_i   (CLK_I),
		.we_i    (mem_we),
		.addr_i  ({port, dw}),
		.wdata_i (WDATA_I),
		.be_i    (BE_I),
		.rdata_o (mem_rdata)
	);

	// Answer path
	// Completion two edges after the request; storage read lands in between
	always_comb begin
		next_pend     = REQ_I;
		next_pend_hit = impl;
		next_pend_src = SRC_I;
		next_pend_wr  = WR_I;
		next_ack      = pend;
		next_hit      = pend ? pend_hit : hit;
		next_rdata    = rdata;
		if (pend) begin
			if (pend_wr) begin
				next_rdata = ZERO_DATA;
			end else if (pend_hit) begin
				next_rdata = mem_rdata;
			end else begin
				next_rdata = miss_data; // RULE8 RULE9
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pend     <= 1'b0;
			pend_hit <= 1'b0;
			pend_src <= PCSAD_SRC_PCIE;
			pend_wr  <= 1'b0;
			ack      <= 1'b0;
			hit      <= 1'b0;
			rdata    <= ZERO_DATA;
		end else begin
			pend     <= next_pend;
			pend_hit <= next_pend_hit;
			pend_src <= next_pend_src;
			pend_wr  <= next_pend_wr;
			ack      <= next_ack;
			hit      <= next_hit;
			rdata    <= next_rdata;
		end
	end

	assign ACK_O   = ack;
	assign HIT_O   = hit;
	assign RDATA_O = rdata;

	// Elaboration checks on the package geometry
	if (MEM_AW != 13) begin : g_bad_mem
		$error("pcsad_top: unsupported address widths");
	end
	if (PORT_AW + OFF_AW != SYS_AW) begin : g_bad_sys
		$error("pcsad_top: system address width mismatch");
	end
	if (PORT_CNT > (1 << PORT_AW)) begin : g_bad_cnt
		$error("pcsad_top: too many ports for port field");
	end
	if (int'(LAST_PORT) != PORT_CNT - 1) begin : g_bad_last
		$error("pcsad_top: last port index mismatch");
	end
	if (DW != 32) begin : g_bad_dw
		$error("pcsad_top: data width must match byte enables");
	end
	if (PORT_STRIDE != (16'h0001 << OFF_AW)) begin : g_bad_stride
		$error("pcsad_top: port stride must match offset width"); // RULE2
	end
	if (UP_BASE != 16'h0000) begin : g_bad_base
		$error("pcsad_top: upstream base must be zero"); // RULE1
	end
endmodule

// ===== core/pcsad_pkg.sv
// Constants for the port configuration space address decoder
package pcsad_pkg;
	localparam int          PORT_CNT       = 6;
	localparam int          SYS_AW         = 15;
	localparam int          OFF_AW         = 12;
	localparam int          PORT_AW        = 3;
	localparam int          DW             = 32;
	localparam logic [15:0] PORT_STRIDE    = 16'h1000;
	localparam logic [15:0] UP_BASE        = 16'h0000;
	localparam logic [2:0]  UP_PORT        = 3'h0;
	localparam logic [2:0]  LAST_PORT      = 3'h5;
	// Register groups found in one port's map (dword offsets)
	localparam logic [9:0]  STD_HDR_LO     = 10'h000;
	localparam logic [9:0]  STD_HDR_HI     = 10'h03F;
	localparam logic [9:0]  MSI_LO         = 10'h034;
	localparam logic [9:0]  MSI_HI         = 10'h037;
	localparam logic [9:0]  GLOBAL_LO      = 10'h100;
	localparam logic [9:0]  GLOBAL_HI      = 10'h1FF;
	localparam logic [9:0]  TEST_LO        = 10'h200;
	localparam logic [9:0]  TEST_HI        = 10'h27F;
	localparam logic [9:0]  EXT_LO         = 10'h040;
	localparam logic [9:0]  EXT_HI         = 10'h0FF;
	localparam logic [31:0] ZERO_DATA      = 32'h0000_0000;
	localparam logic [31:0] UNDEF_DATA     = 32'hDEAD_BEEF;
	typedef enum logic [1:0] {PCSAD_SRC_PCIE, PCSAD_SRC_SMB, PCSAD_SRC_EEP} pcsad_src_e;
endpackage

// ===== core/pcsad_regmem.sv
// Register storage for all six port configuration spaces
`timescale 1ns/1ps
module pcsad_regmem #(
	parameter int AW = 13,
	parameter int DW = 32
) (
	input  wire logic          clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic [3:0]    be_i,
	output logic      [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			for (int b = 0; b < 4; b++) begin
				if (be_i[b]) begin
					mem[addr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
				end
			end
		end
		rdata <= mem[addr_i];
	end

	assign rdata_o = rdata;
endmodule

// ===== bench/pcsad_checker.sv
// Port assertions for the config address decoder
`timescale 1ns/1ps
module pcsad_checker import pcsad_pkg::*; (
	input wire logic              CLK_I, RST_N_I, REQ_I, WR_I, ACK_O, HIT_O,
	input wire pcsad_src_e        SRC_I,
	input wire logic [SYS_AW-1:0] SYS_ADDR_I,
	input wire logic [DW-1:0]     RDATA_O);
	wire logic       sm = SRC_I != PCSAD_SRC_PCIE;
	wire logic [2:0] pt = SYS_ADDR_I[14:12];
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_miss; ##2 ACK_O && !HIT_O; endsequence
	a_ack_lat: assert property (REQ_I |-> ##2 ACK_O) else $error("ack");
	a_wr_zero: assert property (ACK_O && $past(WR_I, 2) |-> !RDATA_O) else $error("wr");
	a_pci_zero: assert property (ACK_O && !HIT_O && !$past(sm, 2) |-> !RDATA_O) else $error("rd");
	a_port_over: assert property (REQ_I && sm && pt > LAST_PORT |-> s_miss) else $error("pt");
	a_glob_up: assert property (REQ_I && sm && pt != 0 && SYS_ADDR_I[11:10] == 1 |-> s_miss)
		else $error("glob");
	a_msi_down: assert property (REQ_I && sm && pt == 0 && SYS_ADDR_I[11:4] == 8'h0D |-> s_miss)
		else $error("msi");
	a_hdr_hit: assert property (REQ_I && sm && pt < 6 && SYS_ADDR_I[11:6] == 0 |-> ##2 HIT_O)
		else $error("hdr");
	a_rd_hold: assert property (!ACK_O |-> $stable(RDATA_O)) else $error("hold");
endmodule

// ===== bench/pcsad_host.sv
// Requester model: root, SMBus master, EEPROM loader
`timescale 1ns/1ps
module pcsad_host import pcsad_pkg::*; (
	input wire logic           CLK_I, ACK_O, HIT_O,
	input wire logic [DW-1:0]  RDATA_O,
	output logic               REQ_I = 0, WR_I = 0,
	output pcsad_src_e         SRC_I = PCSAD_SRC_PCIE,
	output logic [PORT_AW-1:0] CFG_PORT_I = 0,
	output logic [SYS_AW-1:0]  SYS_ADDR_I = 0,
	output logic [3:0]         BE_I = 0,
	output logic [DW-1:0]      WDATA_I = 0);
	logic          a, h;
	logic [DW-1:0] r;
	task automatic acc(pcsad_src_e s, logic w, logic [14:0] x, logic [31:0] d);
		@(posedge CLK_I) #1;
		SRC_I = s;
		{REQ_I, WR_I, CFG_PORT_I, SYS_ADDR_I, BE_I, WDATA_I} = {1'b1, w, x[14:12], x, 4'hF, d};
		@(posedge CLK_I) #1;
		{REQ_I, SYS_ADDR_I, WDATA_I} = {1'b0, ~x, ~d};
		@(posedge CLK_I) #1;
		{a, h, r} = {ACK_O, HIT_O, RDATA_O};
	endtask
endmodule

// ===== bench/tb_port_config_space_address_decode.sv
// Self-checking bench for the config address decoder
`timescale 1ns/1ps
module tb_port_config_space_address_decode;
	import pcsad_pkg::*;
	logic               CLK_I = 0, RST_N_I = 0, REQ_I, WR_I, ACK_O, HIT_O;
	pcsad_src_e         SRC_I;
	logic [PORT_AW-1:0] CFG_PORT_I;
	logic [SYS_AW-1:0]  SYS_ADDR_I;
	logic [3:0]         BE_I;
	logic [DW-1:0]      WDATA_I, RDATA_O;
	int                 n_mismatch = 0, checks_done = 0;
	int                 ofs[6] = '{'h0, 'hD0, 'h3FC, 'h400, 'h9FC, 'hA00};
	logic [31:0]        mem[int];
	pcsad_top DUT (.*);
	pcsad_host host (.*);
	always #10 CLK_I = ~CLK_I;
	function automatic logic imp(int p, int o);
		if (p > 5 || o >= 'hA00) return 0;
		if (o < 'h400) return p != 0 || o < 'hD0 || o >= 'hE0;
		return p == 0;
	endfunction
	task automatic chk(logic [31:0] seen, logic [31:0] exp, string nm);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic go(int s, int w, int p, int o);
		int k = p * 'h1000 + o;
		logic [31:0] d = $urandom;
		logic i = imp(p, o);
		host.acc(pcsad_src_e'(s), w[0], k[14:0], d);
		chk(host.a, 1, "ack");
		chk(host.h, i, "hit");
		if (w[0]) begin
			chk(host.r, 0, "wdata");
			if (i) mem[k] = d;
		end else if (!i) begin
			if (s == 0) chk(host.r, 0, "rdata");
		end else if (mem.exists(k)) chk(host.r, mem[k], "rdata");
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(67));
		#40 RST_N_I = 1;
		for (int p = 0; p < 8; p++) foreach (ofs[j]) begin
			go(2, 1, p, ofs[j]);
			go(0, 0, p, ofs[j]);
			go(1, 0, p, ofs[j]);
		end
		repeat (200) go($urandom % 3, $urandom, $urandom % 8, $urandom % 'hA80 & ~3);
		tally_and_finish;
	end
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule
bind pcsad_top pcsad_checker chk_u (.*);
